// File: hdl/timer_counter_map.vh
`ifndef TIMER_COUNTER_MAP_VH
`define TIMER_COUNTER_MAP_VH

// register byte offsets on the apb bus
`define TC_OFF_CTRL 8'h00
`define TC_OFF_COUNT_LOW 8'h04
`define TC_OFF_COUNT_HIGH 8'h08
`define TC_OFF_IRQ_STATUS 8'h0C
`define TC_OFF_IRQ_MASK 8'h10

// counter_control field positions
`define TC_CTRL_COUNT_EN 0
`define TC_CTRL_SRC_SEL 1
`define TC_CTRL_SYNC_BYPASS 2
`define TC_CTRL_OSC_EN 3
`define TC_CTRL_DIV_LO 4
`define TC_CTRL_DIV_HI 5
`define TC_CTRL_OSC_IN_USE 6
`define TC_CTRL_WIDE 7

// interrupt status and mask field positions
`define TC_IRQ_OVERFLOW 0

// reset values
`define TC_CTRL_RESET 8'h00
`define TC_COUNT_RESET 16'h0000
`define TC_HBUF_RESET 8'h00
`define TC_IRQ_RESET 1'b0

// count values
`define TC_COUNT_MAX 16'hFFFF
`define TC_INSN_LAST 2'h3

`endif

// File: hdl/pin_edge_sync.v
`timescale 1ns/10ps
module pin_edge_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // raw pins
  input wire [WIDTH-1:0] pin_i,
  // synchronised level and rising edge pulse
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] prev_reg;

  // meta_reg feeds sync_reg only; edges are found one stage later
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
      prev_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;

endmodule // pin_edge_sync

// File: hdl/sixteen_bit_timer_counter.v
`timescale 1ns/10ps
`include "timer_counter_map.vh"
module sixteen_bit_timer_counter #(
  parameter ADDR_WIDTH = 8
) (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_WIDTH-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output wire [31:0] prdata_o,
  // count pins
  input wire ext_count_clock_pin_i,
  input wire crystal_in_pin_i,
  // port c interface for the two oscillator pins
  input wire [1:0] port_c_direction_i,
  output wire [1:0] port_c_direction_o,
  output wire [1:0] port_pin_value_o,
  // oscillator and clock system
  input wire sys_clock_from_osc_i,
  output wire crystal_osc_run_o,
  // special event trigger from compare channel
  input wire special_event_i,
  // interrupt
  output wire overflow_flag_o,
  output wire irq_o
);

  // control fields
  reg count_enable_reg;
  reg source_select_reg;
  reg ext_sync_bypass_reg;
  reg crystal_osc_enable_reg;
  reg [1:0] input_divider_select_reg;
  reg wide_access_enable_reg;
  // counter state
  reg [15:0] count_reg;
  reg [7:0] high_buffer_reg;
  reg [2:0] prescale_reg;
  reg [1:0] insn_div_reg;
  reg ext_pending_reg;
  // interrupt state
  reg overflow_flag_reg;
  reg overflow_irq_enable_reg;
  // bus
  reg [31:0] prdata_reg;
  reg [31:0] rdata_next;
  reg mapped;
  reg osc_in_use_reg;

  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire insn_tick;
  wire src_edge;
  wire source_event;
  wire [2:0] prescale_last;
  wire count_tick;
  wire async_mode;
  wire setup_phase;
  wire wr_access;
  wire rd_setup;
  wire wr_ctrl;
  wire wr_low;
  wire wr_high;
  wire wr_status;
  wire wr_mask;
  wire rd_low;
  wire overflow_event;
  wire trigger_reset;

  pin_edge_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i({crystal_in_pin_i, ext_count_clock_pin_i}),
    .level_o(pin_level),
    .rise_o(pin_rise)
  );

  // apb decode; zero wait state, so pready is high for every access
  assign setup_phase = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & pwrite_i;
  assign rd_setup = setup_phase & ~pwrite_i;
  assign wr_ctrl = wr_access & (paddr_i == `TC_OFF_CTRL);
  assign wr_low = wr_access & (paddr_i == `TC_OFF_COUNT_LOW);
  assign wr_high = wr_access & (paddr_i == `TC_OFF_COUNT_HIGH);
  assign wr_status = wr_access & (paddr_i == `TC_OFF_IRQ_STATUS);
  assign wr_mask = wr_access & (paddr_i == `TC_OFF_IRQ_MASK);
  assign rd_low = rd_setup & (paddr_i == `TC_OFF_COUNT_LOW);

  always @* begin
    mapped = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr_i)
      `TC_OFF_CTRL: begin
        rdata_next[`TC_CTRL_COUNT_EN] = count_enable_reg;
        rdata_next[`TC_CTRL_SRC_SEL] = source_select_reg;
        rdata_next[`TC_CTRL_SYNC_BYPASS] = ext_sync_bypass_reg;
        rdata_next[`TC_CTRL_OSC_EN] = crystal_osc_enable_reg;
        rdata_next[`TC_CTRL_DIV_HI:`TC_CTRL_DIV_LO] = input_divider_select_reg;
        rdata_next[`TC_CTRL_OSC_IN_USE] = osc_in_use_reg;
        rdata_next[`TC_CTRL_WIDE] = wide_access_enable_reg;
      end
      `TC_OFF_COUNT_LOW: begin
        rdata_next[7:0] = count_reg[7:0];
      end
      `TC_OFF_COUNT_HIGH: begin
        // wide mode shows the buffer only, never the live byte
        rdata_next[7:0] = wide_access_enable_reg ? high_buffer_reg
                                                 : count_reg[15:8];
      end
      `TC_OFF_IRQ_STATUS: begin
        rdata_next[`TC_IRQ_OVERFLOW] = overflow_flag_reg;
      end
      `TC_OFF_IRQ_MASK: begin
        rdata_next[`TC_IRQ_OVERFLOW] = overflow_irq_enable_reg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data is captured in the setup cycle so the low byte and the
  // high buffer copy come from the same count value
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rdata_next;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = prdata_reg;

  // status of the system clock source, kept in a flop for a steady read
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_in_use_reg <= 1'b0;
    end else begin
      osc_in_use_reg <= sys_clock_from_osc_i;
    end
  end

  // control register; bit 6 is read-only
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_enable_reg <= 1'b0;
      source_select_reg <= 1'b0;
      ext_sync_bypass_reg <= 1'b0;
      crystal_osc_enable_reg <= 1'b0;
      input_divider_select_reg <= 2'h0;
      wide_access_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      count_enable_reg <= pwdata_i[`TC_CTRL_COUNT_EN];
      source_select_reg <= pwdata_i[`TC_CTRL_SRC_SEL];
      ext_sync_bypass_reg <= pwdata_i[`TC_CTRL_SYNC_BYPASS];
      crystal_osc_enable_reg <= pwdata_i[`TC_CTRL_OSC_EN];
      input_divider_select_reg <= pwdata_i[`TC_CTRL_DIV_HI:`TC_CTRL_DIV_LO];
      wide_access_enable_reg <= pwdata_i[`TC_CTRL_WIDE];
    end
  end

  // instruction cycle is one system clock in four
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      insn_div_reg <= 2'h0;
    end else begin
      insn_div_reg <= insn_div_reg + 2'h1;
    end
  end
  assign insn_tick = (insn_div_reg == `TC_INSN_LAST);

  // crystal input is the source when the oscillator runs, otherwise the pin
  assign src_edge = crystal_osc_enable_reg ? pin_rise[1] : pin_rise[0];
  assign async_mode = source_select_reg & ext_sync_bypass_reg;

  // synchronous mode holds an edge until the next instruction cycle;
  // a new edge in the same cycle as the release is kept (set wins)
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_pending_reg <= 1'b0;
    end else if (!count_enable_reg || !source_select_reg) begin
      ext_pending_reg <= 1'b0;
    end else begin
      ext_pending_reg <= (ext_pending_reg & ~insn_tick) | src_edge;
    end
  end

  // bypass only matters with the external source selected
  assign source_event = !source_select_reg ? insn_tick
                      : ext_sync_bypass_reg ? src_edge
                      : (insn_tick & ext_pending_reg);

  // prescaler passes every 1, 2, 4 or 8 source events
  assign prescale_last = (3'h1 << input_divider_select_reg) - 3'h1;
  assign count_tick = count_enable_reg & source_event
                    & (prescale_reg == prescale_last);

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_reg <= 3'h0;
    end else if (wr_low) begin
      prescale_reg <= 3'h0;
    end else if (count_enable_reg && source_event) begin
      if (prescale_reg >= prescale_last) begin
        prescale_reg <= 3'h0;
      end else begin
        prescale_reg <= prescale_reg + 3'h1;
      end
    end
  end

  // the trigger is not honoured in asynchronous counting
  assign trigger_reset = special_event_i & ~async_mode;
  // a wide-mode high write only fills the buffer, so it must not cost a tick
  assign overflow_event = count_tick & ~wr_low & ~(wr_high & ~wide_access_enable_reg)
                        & ~trigger_reset
                        & (count_reg == `TC_COUNT_MAX);

  // writes beat the trigger, which beats an increment
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= `TC_COUNT_RESET;
    end else if (wr_low) begin
      if (wide_access_enable_reg) begin
        count_reg <= {high_buffer_reg, pwdata_i[7:0]};
      end else begin
        count_reg[7:0] <= pwdata_i[7:0];
      end
    end else if (wr_high && !wide_access_enable_reg) begin
      count_reg[15:8] <= pwdata_i[7:0];
    end else if (trigger_reset) begin
      count_reg <= `TC_COUNT_RESET;
    end else if (count_tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // high byte buffer: in wide mode only, filled by low-byte reads or high-address writes
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_buffer_reg <= `TC_HBUF_RESET;
    end else if (wide_access_enable_reg) begin
      if (wr_high) begin
        high_buffer_reg <= pwdata_i[7:0];
      end else if (rd_low) begin
        high_buffer_reg <= count_reg[15:8];
      end
    end
  end

  // overflow flag: write one to clear, a new overflow wins over the clear
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag_reg <= `TC_IRQ_RESET;
      overflow_irq_enable_reg <= `TC_IRQ_RESET;
    end else begin
      if (overflow_event) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_status && pwdata_i[`TC_IRQ_OVERFLOW]) begin
        overflow_flag_reg <= 1'b0;
      end
      if (wr_mask) begin
        overflow_irq_enable_reg <= pwdata_i[`TC_IRQ_OVERFLOW];
      end
    end
  end

  assign overflow_flag_o = overflow_flag_reg;
  assign irq_o = overflow_flag_reg & overflow_irq_enable_reg;

  // oscillator enable depends on nothing but the control bit, so no
  // power-managed mode can stop it; start-up wait is left to software
  assign crystal_osc_run_o = crystal_osc_enable_reg;

  // 1 means input on the direction lines; counting forces both pins in
  assign port_c_direction_o = count_enable_reg ? 2'h3 : port_c_direction_i;
  assign port_pin_value_o = count_enable_reg ? 2'h0 : pin_level;

endmodule // sixteen_bit_timer_counter

// File: sim/timer_counter_chk.sv
`timescale 1ns/10ps
`include "timer_counter_map.vh"
module timer_counter_chk #(
  parameter ADDR_WIDTH = 8
) (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_WIDTH-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pslverr_o,
  // pins and flags
  input wire [1:0] port_c_direction_i,
  input wire [1:0] port_c_direction_o,
  input wire [1:0] port_pin_value_o,
  input wire crystal_osc_run_o,
  input wire overflow_flag_o,
  input wire irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_acc = psel_i && penable_i && pwrite_i;
  wire ctrl_wr = wr_acc && paddr_i == `TC_OFF_CTRL;
  wire flag_clr = wr_acc && paddr_i == `TC_OFF_IRQ_STATUS && pwdata_i[0];
  a_irq_needs_flag: assert property (irq_o |-> overflow_flag_o)
    else $error("irq without flag");
  a_flag_stays_set: assert property (overflow_flag_o && !flag_clr |=> overflow_flag_o)
    else $error("flag lost");
  a_flag_clear_cause: assert property ($fell(overflow_flag_o) |-> $past(flag_clr))
    else $error("flag fell without clear");
  a_pins_read_zero: assert property
    (port_c_direction_o != port_c_direction_i |-> port_pin_value_o == 2'b00)
    else $error("pin value not zero");
  a_enable_makes_inputs: assert property
    (ctrl_wr && pwdata_i[0] |=> (port_c_direction_o == 2'b11) [*2])
    else $error("pins not inputs");
  a_osc_follows_write: assert property
    (ctrl_wr |=> crystal_osc_run_o == $past(pwdata_i[3]))
    else $error("osc enable wrong");
  a_osc_held_stable: assert property (!ctrl_wr |=> $stable(crystal_osc_run_o))
    else $error("osc enable moved");
  a_err_access_only: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access");
endmodule // timer_counter_chk

bind sixteen_bit_timer_counter timer_counter_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_timer_counter_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pslverr_o(pslverr_o),
  .port_c_direction_i(port_c_direction_i), .port_c_direction_o(port_c_direction_o),
  .port_pin_value_o(port_pin_value_o), .crystal_osc_run_o(crystal_osc_run_o),
  .overflow_flag_o(overflow_flag_o), .irq_o(irq_o)
);

// File: sim/clock_source_model.sv
`timescale 1ns/10ps
module clock_source_model (
  input wire run_i,
  input wire osc_run_i,
  output wire ext_pin_o,
  output wire xtal_pin_o
);
  logic phase = 1'b0;
  // 48 ns source; rests low between frames so no stray edge is counted
  always begin
    #24;
    phase = run_i ? ~phase : 1'b0;
  end
  assign ext_pin_o = phase;
  // a shut-off oscillator gives no edges at all
  assign xtal_pin_o = phase && osc_run_i;
endmodule // clock_source_model

// File: sim/sixteen_bit_timer_counter_tb.sv
`timescale 1ns/10ps
`include "timer_counter_map.vh"
module sixteen_bit_timer_counter_tb;
  localparam logic [7:0] ctl = `TC_OFF_CTRL;
  localparam logic [7:0] lo = `TC_OFF_COUNT_LOW;
  localparam logic [7:0] hi = `TC_OFF_COUNT_HIGH;
  localparam logic [7:0] st = `TC_OFF_IRQ_STATUS;
  localparam logic [7:0] mk = `TC_OFF_IRQ_MASK;
  logic clock_i = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata;
  logic sys_osc = 1'b0, special = 1'b0, run = 1'b0;
  logic [1:0] dir_in = 2'b01;
  wire pready, pslverr, ext_pin, xtal_pin, osc_run, flag, irq;
  wire [31:0] prdata;
  wire [1:0] dir_out, pin_val;
  int mismatches = 0, comparisons = 0;
  always #2.5 clock_i = ~clock_i;
  sixteen_bit_timer_counter u_sixteen_bit_timer_counter (
    .clock_i(clock_i), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .ext_count_clock_pin_i(ext_pin),
    .crystal_in_pin_i(xtal_pin), .port_c_direction_i(dir_in), .port_c_direction_o(dir_out),
    .port_pin_value_o(pin_val), .sys_clock_from_osc_i(sys_osc),
    .crystal_osc_run_o(osc_run), .special_event_i(special), .overflow_flag_o(flag),
    .irq_o(irq)
  );
  clock_source_model u_clock_source_model (
    .run_i(run), .osc_run_i(osc_run), .ext_pin_o(ext_pin), .xtal_pin_o(xtal_pin)
  );
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask
  task automatic regs_at_reset();
    rd(ctl, 32'h0, "ctrl");
    chk("pready", 32'h1, pready);
    rd(lo, 32'h0, "low");
    rd(hi, 32'h0, "high");
    rd(st, 32'h0, "status");
    rd(mk, 32'h0, "mask");
    rd(8'h14, 32'h0, "unmapped");
    chk("unmapped err", 1, err);
    chk("dir idle", 32'h1, dir_out);
    chk("osc idle", 32'h0, osc_run);
    wr(ctl, 32'h40);
    rd(ctl, 32'h0, "ro bit");
    sys_osc <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(ctl, 32'h40, "osc in use");
    sys_osc <= 1'b0;
  endtask
  task automatic wide_access();
    wr(hi, 32'h11);
    wr(lo, 32'h44);
    rd(hi, 32'h11, "live high");
    wr(ctl, 32'h80);
    wr(hi, 32'h22);
    rd(hi, 32'h22, "buffer");
    rd(lo, 32'h44, "wide low");
    rd(hi, 32'h11, "snapshot");
    wr(hi, 32'hAB);
    wr(lo, 32'hCD);
    wr(ctl, 32'h00);
    rd(hi, 32'hAB, "loaded high");
    rd(lo, 32'hCD, "loaded low");
  endtask
  task automatic internal_rate(input logic [1:0] code);
    int exp;
    logic [31:0] first;
    exp = 259 / (4 << code);
    wr(hi, 32'h0);
    wr(lo, 32'h0);
    wr(ctl, {26'h0, code, 4'h5});
    repeat (256) @(posedge clock_i);
    wr(ctl, {26'h0, code, 4'h4});
    apb(1'b0, lo, 32'h0);
    first = rdata;
    comparisons++;
    if ((first + 1 >= exp && first <= exp + 1) !== 1'b1) begin
      mismatches++;
      $display("Error rate expected %0d seen %h", exp, first);
    end
    repeat (20) @(posedge clock_i);
    rd(lo, first, "held count");
  endtask
  task automatic overflow_irq();
    wr(mk, 32'h1);
    wr(hi, 32'hFF);
    wr(lo, 32'hF0);
    wr(ctl, 32'h01);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clock_i);
    wr(ctl, 32'h00);
    chk("irq", 1, irq);
    rd(hi, 32'h0, "high after wrap");
    wr(mk, 32'h0);
    @(negedge clock_i);
    chk("masked irq", 0, irq);
    chk("flag", 1, flag);
    wr(st, 32'h1);
    @(negedge clock_i);
    chk("cleared flag", 0, flag);
  endtask
  // count parked at all ones so a tick may meet the trigger
  task automatic trigger_reset();
    wr(hi, 32'hFF);
    wr(lo, 32'hFF);
    wr(ctl, 32'h01);
    special <= 1'b1;
    repeat (4) @(posedge clock_i);
    special <= 1'b0;
    wr(ctl, 32'h00);
    rd(hi, 32'h0, "after trigger");
    chk("trigger flag", 0, flag);
    special <= 1'b1;
    wr(lo, 32'h56);
    special <= 1'b0;
    rd(lo, 32'h56, "write beats trigger");
    wr(ctl, 32'h06);
    special <= 1'b1;
    @(posedge clock_i);
    special <= 1'b0;
    rd(lo, 32'h56, "async ignores trigger");
    wr(ctl, 32'h00);
  endtask
  task automatic pulses(input int n);
    run <= 1'b1;
    repeat (n) @(posedge ext_pin);
    run <= 1'b0;
    repeat (20) @(posedge clock_i);
  endtask
  task automatic port_pins();
    dir_in <= 2'b10;
    wr(ctl, 32'h01);
    @(negedge clock_i);
    chk("dir forced", 32'h3, dir_out);
    run <= 1'b1;
    @(posedge ext_pin);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk("pins read zero", 32'h0, pin_val);
    wr(ctl, 32'h00);
    @(posedge ext_pin);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk("pins free", 32'h1, pin_val);
    chk("dir free", 32'h2, dir_out);
    @(posedge clock_i);
    run <= 1'b0;
    repeat (20) @(posedge clock_i);
  endtask
  // divide by 8: a low write must restart the prescaler, a high write must not
  task automatic prescaler_clear();
    wr(hi, 32'h0);
    wr(lo, 32'h0);
    wr(ctl, 32'h33);
    pulses(5);
    wr(lo, 32'h0);
    pulses(4);
    rd(lo, 32'h0, "prescaler cleared");
    pulses(1);
    wr(hi, 32'h0);
    pulses(4);
    rd(lo, 32'h1, "prescaler kept");
    wr(ctl, 32'h00);
  endtask
  task automatic ext_count(input logic [7:0] c, input int n, input logic [15:0] exp);
    wr(hi, 32'h0);
    wr(lo, 32'h0);
    if (c[3]) begin
      wr(ctl, 32'h08);
      @(negedge clock_i);
      chk("osc run", 32'h1, osc_run);
      repeat (40) @(posedge clock_i);
    end
    wr(ctl, {24'h0, c});
    pulses(n);
    wr(ctl, {24'h0, c & 8'hFE});
    rd(lo, {24'h0, exp[7:0]}, "ext low");
    rd(hi, {24'h0, exp[15:8]}, "ext high");
    chk("osc state", {31'h0, c[3]}, osc_run);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n <= 1'b1;
    regs_at_reset();
    wide_access();
    for (int c = 0; c < 4; c++) internal_rate(c[1:0]);
    overflow_irq();
    trigger_reset();
    port_pins();
    prescaler_clear();
    ext_count(8'h03, 20, 16'd20);
    ext_count(8'h07, 20, 16'd20);
    ext_count(8'h33, 16, 16'd2);
    ext_count(8'h0B, 10, 16'd10);
    final_report();
  end
endmodule // sixteen_bit_timer_counter_tb
